// ===== pkg/iseq_regs.svh
`ifndef ISEQ_REGS_SVH
`define ISEQ_REGS_SVH

// Register offsets on the internal register port.
`define ISEQ_OFS_CTL_TUNE_ONE   8'h46
`define ISEQ_OFS_FWD_TUNE_ONE   8'h47
`define ISEQ_OFS_INPUT_CHOICE   8'h4C
`define ISEQ_OFS_EQ_TEST        8'h4D
`define ISEQ_OFS_EQ_READBACK    8'h4E

// Reset values of the writable registers.
`define ISEQ_RST_CTL_TUNE_ONE   8'h00
`define ISEQ_RST_FWD_TUNE_ONE   8'h00
`define ISEQ_RST_INPUT_CHOICE   8'h00
`define ISEQ_RST_EQ_TEST        8'h20

// Field positions.
`define ISEQ_TERM_HI            3
`define ISEQ_TERM_LO            2
`define ISEQ_SEL_OVERRIDE_BIT   7
`define ISEQ_SEL_CHANNEL_BIT    6
`define ISEQ_EQ_BYPASS_BIT      6
`define ISEQ_EQ_LEVEL_HI        7
`define ISEQ_EQ_LEVEL_LO        4

// Value read back from an address this bank does not own.
`define ISEQ_RD_UNMAPPED        8'h00

// Legal equalization levels, lowest gain to highest.
`define ISEQ_EQ_L0              4'h0
`define ISEQ_EQ_L1              4'h1
`define ISEQ_EQ_L2              4'h3
`define ISEQ_EQ_L3              4'h7
`define ISEQ_EQ_L4              4'hF

`endif

// ===== pkg/iseq_pkg.sv
package iseq_pkg;

  // One register byte.
  typedef logic [7:0] iseq_byte_t;

  // One equalization level code.
  typedef logic [3:0] iseq_level_t;

  // Where the applied equalization level comes from.
  typedef enum logic
  {
    ISEQ_EQ_ADAPTIVE,
    ISEQ_EQ_MANUAL
  } iseq_eq_mode_t;

  // Termination setting of the second input's control link.
  typedef enum logic [1:0]
  {
    ISEQ_TERM_NOMINAL,
    ISEQ_TERM_LOWER,
    ISEQ_TERM_LOWER_MORE,
    ISEQ_TERM_LOWEST
  } iseq_term_t;

endpackage

// ===== hdl/iseq_eq_level.sv
`include "iseq_regs.svh"

module iseq_eq_level
(
  // Clock and reset.
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // Control from the test register.
  input  wire logic                  bypass,
  // Level sources.
  input  wire iseq_pkg::iseq_level_t manual_level,
  input  wire iseq_pkg::iseq_level_t adaptive_level,
  // Results.
  output iseq_pkg::iseq_eq_mode_t    eq_mode,
  output logic                       adaptive_run,
  output iseq_pkg::iseq_level_t      applied_level
);

  // Forces any code onto the legal ladder by keeping the run of ones
  // from bit 0, so a stray manual code never reads back as an illegal one.
  function automatic iseq_pkg::iseq_level_t to_ladder
  (
    input iseq_pkg::iseq_level_t code
  );
    iseq_pkg::iseq_level_t res;
    res = `ISEQ_EQ_L0;
    if (code[0])
      res = `ISEQ_EQ_L1;
    if (code[0] && code[1])
      res = `ISEQ_EQ_L2;
    if (code[0] && code[1] && code[2])
      res = `ISEQ_EQ_L3;
    if (code == `ISEQ_EQ_L4)
      res = `ISEQ_EQ_L4;
    return res;
  endfunction

  iseq_pkg::iseq_eq_mode_t mode_reg;   // Current level source.
  iseq_pkg::iseq_eq_mode_t mode_next;  // Next level source.
  iseq_pkg::iseq_level_t   level_reg;  // Level now applied.
  iseq_pkg::iseq_level_t   level_next; // Next applied level.

  // Bypass stops adaptation and applies the manual level instead.
  always_comb
  begin
    mode_next = bypass ? iseq_pkg::ISEQ_EQ_MANUAL
                       : iseq_pkg::ISEQ_EQ_ADAPTIVE;
    if (bypass)
    begin
      level_next = to_ladder(manual_level);
    end
    else
    begin
      level_next = to_ladder(adaptive_level);
    end
  end

  // Registers the source and the level; reset starts at lowest gain.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      mode_reg  <= iseq_pkg::ISEQ_EQ_ADAPTIVE;
      level_reg <= `ISEQ_EQ_L0;
    end
    else
    begin
      mode_reg  <= mode_next;
      level_reg <= level_next;
    end
  end

  assign eq_mode       = mode_reg;
  assign adaptive_run  = (mode_reg == iseq_pkg::ISEQ_EQ_ADAPTIVE);
  assign applied_level = level_reg;

endmodule // iseq_eq_level

// ===== hdl/iseq_top.sv
// Overview of operation
// - Override bit picks register or pin select.
// - Channel bit 0 routes input 0, 1 routes 1.
// - Bypass stops adaptation, applies manual level.
// - Read-only field shows applied thermometer level.
// - Termination field chooses one of four settings.
`include "iseq_regs.svh"

module iseq_top
(
  // Clock and reset.
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // Internal register port from the control bus slave.
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire iseq_pkg::iseq_byte_t  reg_wdata,
  output iseq_pkg::iseq_byte_t       reg_rdata,
  output logic                       reg_hit,
  // External input-select pin, asynchronous.
  input  wire logic                  input_select_pin,
  // Equalizer level sources.
  input  wire iseq_pkg::iseq_level_t manual_eq_level,
  input  wire iseq_pkg::iseq_level_t adaptive_eq_level,
  // Input routing and equalizer control.
  output logic                       active_input,
  output logic                       adaptive_equalizer_run,
  output iseq_pkg::iseq_eq_mode_t    eq_mode,
  output iseq_pkg::iseq_level_t      applied_eq_level,
  // Second serial input tuning.
  output iseq_pkg::iseq_term_t       second_serial_input_term,
  output iseq_pkg::iseq_byte_t       second_serial_input_impedance
);

  // True when the address belongs to this bank. Used by both the write
  // and read paths so that they can never disagree about the map.
  function automatic logic bank_owns
  (
    input logic [7:0] addr
  );
    logic owns;
    owns = (addr == `ISEQ_OFS_CTL_TUNE_ONE) ||
           (addr == `ISEQ_OFS_FWD_TUNE_ONE) ||
           (addr == `ISEQ_OFS_INPUT_CHOICE) ||
           (addr == `ISEQ_OFS_EQ_TEST)      ||
           (addr == `ISEQ_OFS_EQ_READBACK);
    return owns;
  endfunction

  // Writable registers and their next values.
  iseq_pkg::iseq_byte_t ctl_tune_one_reg;    // Control-link tuning, input 1.
  iseq_pkg::iseq_byte_t ctl_tune_one_next;
  iseq_pkg::iseq_byte_t fwd_tune_one_reg;    // Forward tuning, input 1.
  iseq_pkg::iseq_byte_t fwd_tune_one_next;
  iseq_pkg::iseq_byte_t input_choice_reg;    // Input choice register.
  iseq_pkg::iseq_byte_t input_choice_next;
  iseq_pkg::iseq_byte_t eq_test_reg;         // Equalizer test choice.
  iseq_pkg::iseq_byte_t eq_test_next;

  // Read path state.
  iseq_pkg::iseq_byte_t rdata_reg;           // Read data held for the bus.
  iseq_pkg::iseq_byte_t rdata_next;
  logic                 hit_reg;             // Last read hit this bank.
  logic                 hit_next;

  // Select pin synchroniser and routing state.
  logic                 sel_meta_reg;        // First stage, read by stage 2.
  logic                 sel_sync_reg;        // Second stage, safe to use.
  logic                 active_reg;          // Routed serial input.
  logic                 active_next;

  // Readback byte assembled from the applied level.
  iseq_pkg::iseq_byte_t readback_byte;

  // Write decode. Writes touch all eight bits, so reserved fields take
  // whatever software writes; software is expected to read-modify-write.
  always_comb
  begin
    ctl_tune_one_next = ctl_tune_one_reg;
    fwd_tune_one_next = fwd_tune_one_reg;
    input_choice_next = input_choice_reg;
    eq_test_next      = eq_test_reg;
    if (reg_wr && bank_owns(reg_addr))
    begin
      unique case (reg_addr)
        `ISEQ_OFS_CTL_TUNE_ONE:
        begin
          ctl_tune_one_next = reg_wdata;
        end
        `ISEQ_OFS_FWD_TUNE_ONE:
        begin
          fwd_tune_one_next = reg_wdata;
        end
        `ISEQ_OFS_INPUT_CHOICE:
        begin
          input_choice_next = reg_wdata;
        end
        `ISEQ_OFS_EQ_TEST:
        begin
          eq_test_next = reg_wdata;
        end
        default:
        begin
          // The readback register is read only; a write is dropped.
          ctl_tune_one_next = ctl_tune_one_reg;
        end
      endcase
    end
  end

  // Holds the writable registers; reset restores the documented values.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctl_tune_one_reg <= `ISEQ_RST_CTL_TUNE_ONE;
      fwd_tune_one_reg <= `ISEQ_RST_FWD_TUNE_ONE;
      input_choice_reg <= `ISEQ_RST_INPUT_CHOICE;
      eq_test_reg      <= `ISEQ_RST_EQ_TEST;
    end
    else
    begin
      ctl_tune_one_reg <= ctl_tune_one_next;
      fwd_tune_one_reg <= fwd_tune_one_next;
      input_choice_reg <= input_choice_next;
      eq_test_reg      <= eq_test_next;
    end
  end

  // The select pin comes from outside, so it passes two flip-flops.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sel_meta_reg <= 1'b0;
      sel_sync_reg <= 1'b0;
    end
    else
    begin
      sel_meta_reg <= input_select_pin;
      sel_sync_reg <= sel_meta_reg;
    end
  end

  // Chooses the source of the active input. The register bit only
  // counts while the override is set; otherwise the pin rules.
  always_comb
  begin
    if (input_choice_reg[`ISEQ_SEL_OVERRIDE_BIT])
    begin
      // With the override set, bit 6 names the channel.
      active_next = input_choice_reg[`ISEQ_SEL_CHANNEL_BIT];
    end
    else
    begin
      active_next = sel_sync_reg;
    end
  end

  // Registers the routing so the mux control never glitches.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      active_reg <= 1'b0;
    end
    else
    begin
      active_reg <= active_next;
    end
  end

  // Picks the applied level and the equalizer mode.
  iseq_eq_level u_eq_level
  (
    .ref_clk        (ref_clk),
    .srst           (srst),
    .bypass         (eq_test_reg[`ISEQ_EQ_BYPASS_BIT]),
    .manual_level   (manual_eq_level),
    .adaptive_level (adaptive_eq_level),
    .eq_mode        (eq_mode),
    .adaptive_run   (adaptive_equalizer_run),
    .applied_level  (applied_eq_level)
  );

  // Level in the high nibble; the reserved low nibble reads zero.
  always_comb
  begin
    readback_byte = `ISEQ_RD_UNMAPPED;
    readback_byte[`ISEQ_EQ_LEVEL_HI:`ISEQ_EQ_LEVEL_LO] =
      applied_eq_level;
  end

  // Read mux. Data is captured on the read strobe and held until the
  // next read, so the bus slave may sample it at leisure.
  always_comb
  begin
    rdata_next = rdata_reg;
    hit_next   = hit_reg;
    if (reg_rd)
    begin
      hit_next = bank_owns(reg_addr);
      unique case (reg_addr)
        `ISEQ_OFS_CTL_TUNE_ONE:
        begin
          rdata_next = ctl_tune_one_reg;
        end
        `ISEQ_OFS_FWD_TUNE_ONE:
        begin
          rdata_next = fwd_tune_one_reg;
        end
        `ISEQ_OFS_INPUT_CHOICE:
        begin
          rdata_next = input_choice_reg;
        end
        `ISEQ_OFS_EQ_TEST:
        begin
          rdata_next = eq_test_reg;
        end
        `ISEQ_OFS_EQ_READBACK:
        begin
          rdata_next = readback_byte;
        end
        default:
        begin
          // Other addresses belong to neighbouring banks.
          rdata_next = `ISEQ_RD_UNMAPPED;
        end
      endcase
    end
  end

  // Registers the read answer.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rdata_reg <= `ISEQ_RD_UNMAPPED;
      hit_reg   <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      hit_reg   <= hit_next;
    end
  end

  // Outputs. The impedance byte is passed as written; the analog side
  // gives it meaning, and the default of zero is the safe setting.
  assign reg_rdata                     = rdata_reg;
  assign reg_hit                       = hit_reg;
  assign active_input                  = active_reg;
  assign second_serial_input_term      =
    iseq_pkg::iseq_term_t'(
      ctl_tune_one_reg[`ISEQ_TERM_HI:`ISEQ_TERM_LO]);
  assign second_serial_input_impedance = fwd_tune_one_reg;

endmodule // iseq_top

// ===== tb/iseq_top_properties.sv
module iseq_checker
(
  // Clock and reset.
  input wire logic                    ref_clk,
  input wire logic                    srst,
  // Register port.
  input wire logic [7:0]              reg_addr,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire iseq_pkg::iseq_byte_t    reg_wdata,
  input wire iseq_pkg::iseq_byte_t    reg_rdata,
  input wire logic                    reg_hit,
  // Level sources.
  input wire iseq_pkg::iseq_level_t   manual_eq_level,
  input wire iseq_pkg::iseq_level_t   adaptive_eq_level,
  // Routing, equalizer and tuning results.
  input wire logic                    active_input,
  input wire logic                    adaptive_equalizer_run,
  input wire iseq_pkg::iseq_eq_mode_t eq_mode,
  input wire iseq_pkg::iseq_level_t   applied_eq_level,
  input wire iseq_pkg::iseq_term_t    second_serial_input_term,
  input wire iseq_pkg::iseq_byte_t    second_serial_input_impedance
);
  timeunit 1ns;
  timeprecision 100ps;

  // One clock domain, so one default clock and reset serve all.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Outputs are checked two edges after a write, which covers both
  // a one and a two cycle output latency.
  a_chan_by_reg: assert property (reg_wr &&
    reg_addr == 8'h4C && reg_wdata[7]
    |-> ##2 active_input == $past(reg_wdata[6], 2))
    else $error("active input ignores the register choice");
  a_bypass_mode: assert property (reg_wr && reg_addr == 8'h4D
    |-> ##2 eq_mode == $past(reg_wdata[6], 2))
    else $error("equalizer mode does not follow bypass bit");
  a_run_vs_mode: assert property (adaptive_equalizer_run ==
    (eq_mode == iseq_pkg::ISEQ_EQ_ADAPTIVE))
    else $error("adaptation runs in the wrong mode");
  a_level_adapt: assert property (!$past(srst) &&
    eq_mode == iseq_pkg::ISEQ_EQ_ADAPTIVE &&
    $past(adaptive_eq_level) inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF}
    |-> applied_eq_level == $past(adaptive_eq_level))
    else $error("applied level is not the adaptive one");
  a_level_manual: assert property (!$past(srst) &&
    eq_mode == iseq_pkg::ISEQ_EQ_MANUAL &&
    $past(manual_eq_level) inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF}
    |-> applied_eq_level == $past(manual_eq_level))
    else $error("applied level is not the manual one");
  a_term_write: assert property (reg_wr && reg_addr == 8'h46
    |-> ##2 second_serial_input_term == $past(reg_wdata[3:2], 2))
    else $error("termination does not follow its field");
  a_imp_write: assert property (reg_wr && reg_addr == 8'h47
    |-> ##2 second_serial_input_impedance == $past(reg_wdata, 2))
    else $error("impedance does not follow its register");
  a_hit_decode: assert property (reg_rd |=> reg_hit ==
    ($past(reg_addr) inside {8'h46, 8'h47, 8'h4C, 8'h4D, 8'h4E}))
    else $error("hit flag wrong for the read address");
  a_level_read: assert property (reg_rd && reg_addr == 8'h4E
    |=> reg_rdata == {$past(applied_eq_level), 4'h0})
    else $error("level readback differs from applied level");
  a_rdata_hold: assert property (!reg_rd
    |=> $stable(reg_rdata) && $stable(reg_hit))
    else $error("read data changed without a read");
endmodule // iseq_checker

bind iseq_top iseq_checker u_chk (.ref_clk, .srst, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .reg_hit, .manual_eq_level,
  .adaptive_eq_level, .active_input, .adaptive_equalizer_run, .eq_mode,
  .applied_eq_level, .second_serial_input_term,
  .second_serial_input_impedance);

// ===== tb/iseq_top_bench.sv
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module iseq_top_bench;
  timeunit 1ns;
  timeprecision 100ps;

  // Counters of the run.
  int                      num_errors = 0;
  int                      n_checks = 0;
  int                      cyc = 0;
  // Design ports, named as on the design.
  logic                    ref_clk;
  logic                    srst;
  logic [7:0]              reg_addr;
  logic                    reg_wr;
  logic                    reg_rd;
  iseq_pkg::iseq_byte_t    reg_wdata;
  iseq_pkg::iseq_byte_t    reg_rdata;
  logic                    reg_hit;
  logic                    input_select_pin;
  iseq_pkg::iseq_level_t   manual_eq_level;
  iseq_pkg::iseq_level_t   adaptive_eq_level;
  logic                    active_input;
  logic                    adaptive_equalizer_run;
  iseq_pkg::iseq_eq_mode_t eq_mode;
  iseq_pkg::iseq_level_t   applied_eq_level;
  iseq_pkg::iseq_term_t    second_serial_input_term;
  iseq_pkg::iseq_byte_t    second_serial_input_impedance;
  // Legal level codes, lowest gain first.
  logic [3:0]              ladder [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};

  iseq_top dut (.ref_clk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_hit, .input_select_pin, .manual_eq_level,
    .adaptive_eq_level, .active_input, .adaptive_equalizer_run, .eq_mode,
    .applied_eq_level, .second_serial_input_term,
    .second_serial_input_impedance);

  // Free running 200 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hang is cut short well beyond the roughly 126 cycles needed.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  // One write pulse, then two edges so level outputs have settled.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  // One read pulse; data and hit are compared one edge later.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input logic h);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    `CHK(reg_rdata, e)
    `CHK(reg_hit, h)
  endtask

  initial
  begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    input_select_pin = 1'b0;
    manual_eq_level = 4'h0;
    adaptive_eq_level = 4'h0;
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
    // Reset values, an unmapped place and the read-only level.
    rd_chk(8'h46, 8'h00, 1'b1);
    rd_chk(8'h47, 8'h00, 1'b1);
    rd_chk(8'h4C, 8'h00, 1'b1);
    rd_chk(8'h4D, 8'h20, 1'b1);
    wr_reg(8'h48, 8'hFF);
    rd_chk(8'h48, 8'h00, 1'b0);
    wr_reg(8'h4E, 8'hF0);
    rd_chk(8'h4E, 8'h00, 1'b1);
    // Pin choice, then the register override in both channels.
    input_select_pin = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK(active_input, 1'b1)
    wr_reg(8'h4C, 8'h80);
    `CHK(active_input, 1'b0)
    wr_reg(8'h4C, 8'hC0);
    input_select_pin = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(active_input, 1'b1)
    wr_reg(8'h4C, 8'h7F);
    `CHK(active_input, 1'b0)
    rd_chk(8'h4C, 8'h7F, 1'b1);
    // Adaptive then manual: each ladder step is applied and read back.
    for (int b = 0; b < 2; b++)
    begin
      wr_reg(8'h4D, b ? 8'h60 : 8'h20);
      `CHK(eq_mode, iseq_pkg::iseq_eq_mode_t'(b))
      `CHK(adaptive_equalizer_run, (b == 0))
      for (int i = 0; i < 5; i++)
      begin
        adaptive_eq_level = b ? ladder[4 - i] : ladder[i];
        manual_eq_level = b ? ladder[i] : ladder[4 - i];
        @(negedge ref_clk);
        `CHK(applied_eq_level, ladder[i])
        rd_chk(8'h4E, {ladder[i], 4'h0}, 1'b1);
      end
    end
    // An off-ladder manual code is clamped to its run of ones from bit 0.
    manual_eq_level = 4'h5;
    @(negedge ref_clk);
    `CHK(applied_eq_level, 4'h1)
    // Every termination code, with the reserved bits set around it.
    for (int t = 0; t < 4; t++)
    begin
      wr_reg(8'h46, 8'hF3 | 8'(t << 2));
      `CHK(second_serial_input_term, iseq_pkg::iseq_term_t'(t))
      rd_chk(8'h46, 8'hF3 | 8'(t << 2), 1'b1);
    end
    // Long cable impedance setting.
    wr_reg(8'h47, 8'h70);
    `CHK(second_serial_input_impedance, 8'h70)
    rd_chk(8'h47, 8'h70, 1'b1);
    // A reset in mid-run brings the tuning back to its defaults.
    srst = 1'b1;
    repeat (3) @(negedge ref_clk);
    srst = 1'b0;
    `CHK(second_serial_input_term, iseq_pkg::ISEQ_TERM_NOMINAL)
    `CHK(second_serial_input_impedance, 8'h00)
    `CHK(adaptive_equalizer_run, 1'b1)
    `CHK(applied_eq_level, 4'h0)
    rd_chk(8'h4D, 8'h20, 1'b1);
    rd_chk(8'h4C, 8'h00, 1'b1);
    report_and_stop();
  end
endmodule // iseq_top_bench
